// ===== logic/cal_pkg.sv
// Shared constants for the arithmetic, logic and I/O bit-access unit.
package cal_pkg;

  // APB register byte addresses.
  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam logic [11:0] ADDR_FLAGS = 12'h008;
  localparam logic [3:0]  PAGE_GPR   = 4'h1;
  localparam logic [3:0]  PAGE_IO    = 4'h2;

  // Command word fields.
  localparam int OP_LSB   = 0;
  localparam int DST_LSB  = 8;
  localparam int SRC_LSB  = 16;
  localparam int BIT_LSB  = 16;
  localparam int IMM_LSB  = 24;

  // Status word fields.
  localparam int ST_BUSY    = 8;
  localparam int ST_SKIP    = 9;
  localparam int ST_REFUSED = 10;
  localparam int ST_ILLEGAL = 11;

  // Condition flag positions.
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;

  // Reset values.
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // I/O space: top of the bit-accessible range and the flag register.
  localparam logic [5:0] IO_BIT_TOP   = 6'h1F;
  localparam logic [5:0] IO_FLAG_ADDR = 6'h0B;
  localparam logic [7:0] IO_W1C_MASK  = 8'h27;
  localparam logic [5:0] IO_PORT_ADDR = 6'h18;

  // Execution lengths in clock cycles.
  localparam logic [1:0] CYC_BYTE = 2'h1;
  localparam logic [1:0] CYC_WORD = 2'h2;
  localparam logic [1:0] CYC_IO   = 2'h2;

  // Operation codes.
  localparam logic [4:0] OP_ADD         = 5'h00;
  localparam logic [4:0] OP_ADD_CARRY   = 5'h01;
  localparam logic [4:0] OP_SUB         = 5'h02;
  localparam logic [4:0] OP_MINUS_IMM   = 5'h03;
  localparam logic [4:0] OP_BORROW_REG  = 5'h04;
  localparam logic [4:0] OP_BORROW_IMM  = 5'h05;
  localparam logic [4:0] OP_AND         = 5'h06;
  localparam logic [4:0] OP_MASK_IMM    = 5'h07;
  localparam logic [4:0] OP_OR          = 5'h08;
  localparam logic [4:0] OP_MERGE_IMM   = 5'h09;
  localparam logic [4:0] OP_BITS_SET    = 5'h0A;
  localparam logic [4:0] OP_BITS_CLR    = 5'h0B;
  localparam logic [4:0] OP_PROBE       = 5'h0C;
  localparam logic [4:0] OP_PAIR_PLUS   = 5'h0D;
  localparam logic [4:0] OP_PAIR_MINUS  = 5'h0E;
  localparam logic [4:0] OP_IO_SET      = 5'h0F;
  localparam logic [4:0] OP_IO_CLR      = 5'h10;
  localparam logic [4:0] OP_SKIP_HIGH   = 5'h11;
  localparam logic [4:0] OP_SKIP_LOW    = 5'h12;

endpackage

// ===== logic/cal_alu.sv
// Byte-wide arithmetic and logic stage with condition flag update.
`timescale 1ns/1ns
module cal_alu (
  // Operation select.
  input  wire logic [4:0] op,
  // Operands and incoming flags.
  input  wire logic [7:0] dst_val,
  input  wire logic [7:0] src_val,
  input  wire logic [7:0] imm,
  input  wire logic [7:0] flags_in,
  // Result, new flags and write-back request.
  output logic      [7:0] result,
  output logic      [7:0] flags_out,
  output logic            wr
);

  logic [7:0] k;
  logic       use_c;
  logic       is_sub;
  logic       is_arith;
  logic       is_or;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] half5;

  // Decode the operation into operand choice and function.
  always_comb begin
    k        = src_val;
    use_c    = 1'b0;
    is_sub   = 1'b0;
    is_arith = 1'b1;
    is_or    = 1'b0;
    wr       = 1'b1;
    unique case (op)
      cal_pkg::OP_ADD:        k = src_val;
      cal_pkg::OP_ADD_CARRY:  use_c = 1'b1;
      cal_pkg::OP_SUB:        is_sub = 1'b1;
      cal_pkg::OP_MINUS_IMM: begin
        k      = imm;
        is_sub = 1'b1;
      end
      cal_pkg::OP_BORROW_REG: begin
        is_sub = 1'b1;
        use_c  = 1'b1;
      end
      cal_pkg::OP_BORROW_IMM: begin
        k      = imm;
        is_sub = 1'b1;
        use_c  = 1'b1;
      end
      cal_pkg::OP_AND:        is_arith = 1'b0;
      cal_pkg::OP_MASK_IMM: begin
        k        = imm;
        is_arith = 1'b0;
      end
      cal_pkg::OP_OR:         begin
        is_arith = 1'b0;
        is_or    = 1'b1;
      end
      cal_pkg::OP_MERGE_IMM, cal_pkg::OP_BITS_SET: begin
        k        = imm;
        is_arith = 1'b0;
        is_or    = 1'b1;
      end
      cal_pkg::OP_BITS_CLR: begin
        k        = 8'hFF - imm;
        is_arith = 1'b0;
      end
      cal_pkg::OP_PROBE: begin
        k        = dst_val;
        is_arith = 1'b0;
      end
      default: begin
        wr       = 1'b0;
        is_arith = 1'b0;
      end
    endcase
  end

  assign cin = use_c & flags_in[cal_pkg::FL_C];

  // Sum or difference with a separate low nibble for the half carry.
  always_comb begin
    if (is_sub) begin
      sum9  = {1'b0, dst_val} - {1'b0, k} - {8'h00, cin};
      half5 = {1'b0, dst_val[3:0]} - {1'b0, k[3:0]} - {4'h0, cin};
    end else begin
      sum9  = {1'b0, dst_val} + {1'b0, k} + {8'h00, cin};
      half5 = {1'b0, dst_val[3:0]} + {1'b0, k[3:0]} + {4'h0, cin};
    end
  end

  always_comb begin
    flags_out = flags_in;
    result    = dst_val;
    if (is_arith) begin
      result                  = sum9[7:0];
      flags_out[cal_pkg::FL_C] = sum9[8];
      flags_out[cal_pkg::FL_H] = half5[4];
      flags_out[cal_pkg::FL_Z] = (sum9[7:0] == 8'h00);
      flags_out[cal_pkg::FL_N] = sum9[7];
      if (is_sub) begin
        flags_out[cal_pkg::FL_V] = (dst_val[7] & ~k[7] & ~sum9[7]) |
                                   (~dst_val[7] & k[7] & sum9[7]);
      end else begin
        flags_out[cal_pkg::FL_V] = (dst_val[7] & k[7] & ~sum9[7]) |
                                   (~dst_val[7] & ~k[7] & sum9[7]);
      end
    end else if (wr) begin
      result                  = is_or ? (dst_val | k) : (dst_val & k);
      flags_out[cal_pkg::FL_Z] = (result == 8'h00);
      flags_out[cal_pkg::FL_N] = result[7];
      flags_out[cal_pkg::FL_V] = 1'b0;
    end
  end

endmodule

// ===== logic/cal_core.sv
// APB-reached execution unit: byte and word arithmetic, I/O bit access.
`timescale 1ns/1ns
// Overview of operation
// - Add source to destination, optional carry; Z C N V H; one cycle.
// - Add immediate to register pair; Z C N V S; two cycles.
// - Subtract register or immediate; Z C N V H; one cycle.
// - Subtract operand and carry flag; Z C N V H; one cycle.
// - Subtract immediate from register pair; Z C N V S; two cycles.
// - AND with register or immediate; only Z N V; one cycle.
// - OR with register or immediate; only Z N V; one cycle.
// - Set masked bits by OR; Z N V; one cycle.
// - Clear masked bits by AND with FF minus mask; Z N V.
// - AND register with itself to probe zero or sign; one cycle.
// - Single-bit set and clear reach I/O addresses 00 to 1F.
// - Skip tests read one I/O bit and flag the next skip.
// - Bit set and clear write only the addressed bit.
// - Writing one clears status flags; writing zero leaves them.
// - Bit set and clear cannot reach I/O above address 1F.
module cal_core (
  // Clock, reset and clock enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Hardware events that raise flags in the flag I/O register.
  input  wire logic [7:0]  flag_event,
  // I/O port register and skip decision.
  output logic      [7:0]  io_port_q,
  output logic             skip_next
);

  logic [7:0]  gpr_reg [32];
  logic [7:0]  io_reg [64];
  logic [31:0] cmd_reg;
  logic [7:0]  flags_reg;
  logic [1:0]  cnt_reg;
  logic [15:0] word_reg;
  logic        refused_reg;
  logic        illegal_reg;
  logic        skip_reg;

  logic        access;
  logic        wr_ok;
  logic        wr_bad;
  logic        launch;
  logic        busy;
  logic [4:0]  op;
  logic [4:0]  dst;
  logic [4:0]  src;
  logic [5:0]  io_addr;
  logic [2:0]  bit_sel;
  logic [7:0]  imm;
  logic        is_word;
  logic        is_io;
  logic        is_skip;
  logic        op_legal;
  logic [4:0]  pair_lo;
  logic [15:0] pair_val;
  logic [16:0] word_sum;
  logic [7:0]  alu_res;
  logic [7:0]  alu_flags;
  logic        alu_wr;
  logic        bit_ok;
  logic        byte_done;
  logic        word_lo;
  logic        last;
  logic [7:0]  flags_word;

  // Command fields.
  assign op      = cmd_reg[cal_pkg::OP_LSB +: 5];
  assign dst     = cmd_reg[cal_pkg::DST_LSB +: 5];
  assign src     = cmd_reg[cal_pkg::SRC_LSB +: 5];
  assign io_addr = cmd_reg[cal_pkg::DST_LSB +: 6];
  assign bit_sel = cmd_reg[cal_pkg::BIT_LSB +: 3];
  assign imm     = cmd_reg[cal_pkg::IMM_LSB +: 8];
  assign busy    = (cnt_reg != 2'h0);
  assign last    = (cnt_reg == 2'h1);

  // A wait state is inserted on every access, so pready is a flop.
  assign access = psel & penable & pready;
  assign wr_bad = access & pwrite & busy;
  assign wr_ok  = access & pwrite & ~busy;
  assign launch = wr_ok & (paddr == cal_pkg::ADDR_CTRL);

  // Operation class of the held command.
  assign is_word = (op == cal_pkg::OP_PAIR_PLUS) |
                   (op == cal_pkg::OP_PAIR_MINUS);
  assign is_io   = (op == cal_pkg::OP_IO_SET) | (op == cal_pkg::OP_IO_CLR);
  assign is_skip = (op == cal_pkg::OP_SKIP_HIGH) |
                   (op == cal_pkg::OP_SKIP_LOW);
  assign op_legal = (op <= cal_pkg::OP_SKIP_LOW);

  // bit access only up to 1F
  assign bit_ok = (io_addr <= cal_pkg::IO_BIT_TOP);

  // Byte stage shared by all one-cycle arithmetic and logic operations.
  cal_alu u_alu (
    .op        (op),
    .dst_val   (gpr_reg[dst]),
    .src_val   (gpr_reg[src]),
    .imm       (imm),
    .flags_in  (flags_reg),
    .result    (alu_res),
    .flags_out (alu_flags),
    .wr        (alu_wr)
  );

  assign pair_lo  = {dst[4:1], 1'b0};
  assign pair_val = {gpr_reg[pair_lo + 5'h01], gpr_reg[pair_lo]};
  assign word_sum = (op == cal_pkg::OP_PAIR_MINUS) ?
                    ({1'b0, pair_val} - {9'h000, imm}) :
                    ({1'b0, pair_val} + {9'h000, imm});

  // Word flags are taken on the second cycle from the held result.
  always_comb begin
    flags_word = flags_reg;
    flags_word[cal_pkg::FL_Z] = (word_reg == 16'h0000);
    flags_word[cal_pkg::FL_N] = word_reg[15];
    if (op == cal_pkg::OP_PAIR_MINUS) begin
      flags_word[cal_pkg::FL_V] = pair_val[15] & ~word_reg[15];
      flags_word[cal_pkg::FL_C] = word_reg[15] & ~pair_val[15];
    end else begin
      flags_word[cal_pkg::FL_V] = ~pair_val[15] & word_reg[15];
      flags_word[cal_pkg::FL_C] = ~word_reg[15] & pair_val[15];
    end
    flags_word[cal_pkg::FL_S] = flags_word[cal_pkg::FL_N] ^
                                flags_word[cal_pkg::FL_V];
  end

  // Completion points of the held command.
  assign byte_done = last & ~is_word & ~is_io & ~is_skip & alu_wr;
  assign word_lo   = is_word & (cnt_reg == cal_pkg::CYC_WORD);

  // APB handshake: one wait state, then the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
    end
  end

  // Read data and error answer, both settled with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      // Judge busy as it will stand at the completing edge, so that the
      // error answer and the refusal of the write always agree.
      pslverr <= psel & penable & ~pready & pwrite & (cnt_reg > 2'h1);
      prdata  <= 32'h0000_0000;
      if (psel & penable & ~pready & ~pwrite) begin
        if (paddr == cal_pkg::ADDR_CTRL) begin
          prdata <= cmd_reg;
        end else if (paddr == cal_pkg::ADDR_STAT) begin
          prdata <= {20'h0_0000, illegal_reg, refused_reg, skip_reg, busy,
                     flags_reg};
        end else if (paddr == cal_pkg::ADDR_FLAGS) begin
          prdata <= {24'h00_0000, flags_reg};
        end else if (paddr[11:8] == cal_pkg::PAGE_GPR && !paddr[7]) begin
          prdata <= {24'h00_0000, gpr_reg[paddr[6:2]]};
        end else if (paddr[11:8] == cal_pkg::PAGE_IO) begin
          prdata <= {24'h00_0000, io_reg[paddr[7:2]]};
        end
      end
    end
  end

  // Command register and execution cycle counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 32'h0000_0000;
      cnt_reg <= 2'h0;
    end else if (clk_en) begin
      if (launch) begin
        cmd_reg <= pwdata;
        if (pwdata[cal_pkg::OP_LSB +: 5] == cal_pkg::OP_PAIR_PLUS ||
            pwdata[cal_pkg::OP_LSB +: 5] == cal_pkg::OP_PAIR_MINUS) begin
          cnt_reg <= cal_pkg::CYC_WORD;
        end else if (pwdata[cal_pkg::OP_LSB +: 5] == cal_pkg::OP_IO_SET ||
                     pwdata[cal_pkg::OP_LSB +: 5] == cal_pkg::OP_IO_CLR) begin
          cnt_reg <= cal_pkg::CYC_IO;
        end else begin
          cnt_reg <= cal_pkg::CYC_BYTE;
        end
      end else if (busy) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end

  // Error flags: refused writes and unknown or out-of-range commands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_bad) begin
        refused_reg <= 1'b1;
      end else if (launch) begin
        refused_reg <= 1'b0;
      end
      if (launch) begin
        illegal_reg <= 1'b0;
      end else if (last && (!op_legal || ((is_io || is_skip) && !bit_ok))) begin
        illegal_reg <= 1'b1;
      end
    end
  end

  // Condition flags: direct write, byte result or word result.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= cal_pkg::FLAGS_RESET;
      word_reg  <= 16'h0000;
    end else if (clk_en) begin
      if (word_lo) begin
        word_reg <= word_sum[15:0];
      end
      if (wr_ok && paddr == cal_pkg::ADDR_FLAGS) begin
        flags_reg <= pwdata[7:0];
      end else if (byte_done) begin
        flags_reg <= alu_flags;
      end else if (last && is_word) begin
        flags_reg <= flags_word;
      end
    end
  end

  // General registers: software writes and results; the array is
  // reset so that a probe after reset sees a known value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr_reg[i] <= cal_pkg::DATA_RESET;
      end
    end else if (clk_en) begin
      if (wr_ok && paddr[11:8] == cal_pkg::PAGE_GPR && !paddr[7]) begin
        gpr_reg[paddr[6:2]] <= pwdata[7:0];
      end else if (byte_done) begin
        gpr_reg[dst] <= alu_res;
      end else if (word_lo) begin
        gpr_reg[pair_lo] <= word_sum[7:0];
      end else if (last && is_word) begin
        gpr_reg[pair_lo + 5'h01] <= word_reg[15:8];
      end
    end
  end

  // I/O space. Flag bits are set by hardware and cleared by a one;
  // the event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 64; i++) begin
        io_reg[i] <= cal_pkg::DATA_RESET;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 64; i++) begin
        logic [7:0] nv;
        nv = io_reg[i];
        if (wr_ok && paddr[11:8] == cal_pkg::PAGE_IO &&
            paddr[7:2] == 6'(i)) begin
          if (6'(i) == cal_pkg::IO_FLAG_ADDR) begin
            nv = (nv & cal_pkg::IO_W1C_MASK & ~pwdata[7:0]) |
                 (pwdata[7:0] & ~cal_pkg::IO_W1C_MASK);
          end else begin
            nv = pwdata[7:0];
          end
        end
        if (last && is_io && bit_ok && io_addr == 6'(i)) begin
          // only the addressed bit is touched
          if (6'(i) == cal_pkg::IO_FLAG_ADDR &&
              cal_pkg::IO_W1C_MASK[bit_sel]) begin
            if (op == cal_pkg::OP_IO_SET) begin
              nv[bit_sel] = 1'b0;
            end
          end else begin
            nv[bit_sel] = (op == cal_pkg::OP_IO_SET);
          end
        end
        if (6'(i) == cal_pkg::IO_FLAG_ADDR) begin
          nv = nv | (flag_event & cal_pkg::IO_W1C_MASK);
        end
        io_reg[i] <= nv;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_reg <= 1'b0;
    end else if (clk_en) begin
      if (launch) begin
        skip_reg <= 1'b0;
      end else if (last && is_skip && bit_ok) begin
        skip_reg <= (op == cal_pkg::OP_SKIP_HIGH) ?
                    io_reg[io_addr][bit_sel] : ~io_reg[io_addr][bit_sel];
      end
    end
  end

  // Registered copies for the top-level outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_port_q <= cal_pkg::DATA_RESET;
      skip_next <= 1'b0;
    end else if (clk_en) begin
      io_port_q <= io_reg[cal_pkg::IO_PORT_ADDR];
      skip_next <= skip_reg;
    end
  end

endmodule

// ===== sim/cal_core_properties.sv
// Port-level checks of the execution unit's APB timing and outputs.
`timescale 1ns/1ns
module cal_props (
  // Clock, reset and enable.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Port copy and skip decision.
  input wire logic [7:0]  io_port_q,
  input wire logic        skip_next
);
  logic       done_wr;
  logic [3:0] cnt_reg;

  // Outputs may only move a few cycles after an accepted write.
  assign done_wr = psel & penable & pready & pwrite & ~pslverr;

  // Saturating age of the last accepted write; saturation avoids wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'hF;
    end else if (done_wr) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hF) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");
  property p_ready_cause;
    pready |-> psel && penable && $past(psel && penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without an access phase");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("prdata not zero outside an answer");
  property p_one_wait;
    psel && penable && !pready && clk_en |=> pready;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("answer not after one wait state");
  property p_port_write;
    done_wr && paddr == 12'h260 |->
      ##2 {24'h0, io_port_q} == ($past(pwdata, 2) & 32'h0000_00FF);
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("port copy does not follow its write");
  property p_port_cause;
    $changed(io_port_q) |-> cnt_reg <= 4'h4;
  endproperty
  a_port_cause: assert property (p_port_cause)
    else $error("port copy changed without a write");
  property p_skip_cause;
    $changed(skip_next) |-> cnt_reg <= 4'h4;
  endproperty
  a_skip_cause: assert property (p_skip_cause)
    else $error("skip changed without a command");
endmodule

bind cal_core cal_props u_props (.pclk(pclk), .presetn(presetn),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .io_port_q(io_port_q), .skip_next(skip_next));

// ===== sim/tb_core_arith_logic_and_io_bit_access.sv
// Self-checking bench for the arithmetic, logic and I/O bit-access unit.
`timescale 1ns/1ns
module tb_core_arith_logic_and_io_bit_access;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0]  flag_event = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  io_port_q;
  logic        skip_next;
  logic [31:0] seed = 32'h0000_0033;
  logic [31:0] rd_q, r;
  logic [7:0]  mfl, k, m, o, d;
  logic [7:0]  mgpr [32];
  logic [7:0]  mio [64];
  logic [4:0]  op, dst, src;
  logic [5:0]  a;
  int          kd [10] = '{0, 2, 1, 1, 0, 1, 0, 2, 1, 1};
  logic [5:0]  ia [10] = '{6'h0B, 6'h0B, 6'h0B, 6'h0B, 6'h0B, 6'h18,
                           6'h18, 6'h18, 6'h1F, 6'h20};
  logic [7:0]  iv [10] = '{8'h18, 8'h03, 8'h00, 8'h06, 8'h02, 8'h02,
                           8'hA5, 8'h05, 8'h07, 8'h00};
  int          i, b;
  int          num_errors = 0;
  int          checks = 0;

  cal_core dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flag_event(flag_event), .io_port_q(io_port_q),
    .skip_next(skip_next));

  // Clock of 100 ns period.
  always #50 pclk = ~pclk;

  // Repeatable pseudo-random source.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One APB transfer; the answer is taken at the edge that samples pready.
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at pready only at rising edges; take the data at that edge.
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    chk("pslverr", 32'h0000_0000, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic rdchk(input logic [11:0] ad, input logic [31:0] e,
                       input string nm);
    apb(1'b0, ad, 32'h0000_0000);
    chk(nm, e, rd_q);
  endtask

  // Launch a command, then poll until it has finished.
  task automatic cmd(input logic [4:0] c, input logic [5:0] dd,
                     input logic [4:0] ss, input logic [7:0] kk);
    apb(1'b1, cal_pkg::ADDR_CTRL, {kk, 3'h0, ss, 2'h0, dd, 3'h0, c});
    do apb(1'b0, cal_pkg::ADDR_STAT, 32'h0000_0000);
    while (rd_q[cal_pkg::ST_BUSY] !== 1'b0);
  endtask

  // Reference model of one operation on the model registers and flags.
  task automatic alu(input logic [4:0] c, input logic [4:0] dr,
                     input logic [4:0] sr, input logic [7:0] kk);
    logic [7:0]  dv, sv, rv;
    logic [15:0] ov;
    logic [16:0] w;
    logic        ci, ad;
    dv = mgpr[dr];
    sv = (c inside {5'h03, 5'h05, 5'h07, 5'h09, 5'h0A, 5'h0B}) ? kk
         : mgpr[sr];
    ci = (c inside {5'h01, 5'h04, 5'h05}) & mfl[0];
    ad = c <= 5'h01;
    rv = dv;
    if (c >= cal_pkg::OP_PAIR_PLUS) begin
      ov = {mgpr[dr+1], dv};
      w = (c == cal_pkg::OP_PAIR_PLUS) ? {1'b0, ov} + kk : {1'b0, ov} - kk;
      mfl[0] = w[16];
      mfl[1] = w[15:0] == 16'h0000;
      mfl[2] = w[15];
      mfl[3] = (c == cal_pkg::OP_PAIR_PLUS) ? ~ov[15] & w[15]
               : ov[15] & ~w[15];
      mfl[4] = mfl[2] ^ mfl[3];
      mgpr[dr] = w[7:0];
      mgpr[dr+1] = w[15:8];
    end else if (c <= 5'h05) begin
      w = ad ? dv + sv + ci : {9'h000, dv} - sv - ci;
      rv = w[7:0];
      mfl[0] = w[8];
      mfl[5] = ad ? (dv[3] & sv[3]) | (sv[3] & ~rv[3]) | (~rv[3] & dv[3])
               : (~dv[3] & sv[3]) | (sv[3] & rv[3]) | (rv[3] & ~dv[3]);
      mfl[3] = ad ? (dv[7] & sv[7] & ~rv[7]) | (~dv[7] & ~sv[7] & rv[7])
               : (dv[7] & ~sv[7] & ~rv[7]) | (~dv[7] & sv[7] & rv[7]);
    end else begin
      if (c <= 5'h07) rv = dv & sv;
      else if (c == 5'h0B) rv = dv & ~sv;
      else if (c == 5'h0C) rv = dv & dv;
      else rv = dv | sv;
      mfl[3] = 1'b0;
    end
    if (c < cal_pkg::OP_PAIR_PLUS) begin
      mfl[1] = rv == 8'h00;
      mfl[2] = rv[7];
      mgpr[dr] = rv;
    end
  endtask

  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about sixteen hundred cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    for (i = 0; i < 64; i++) mio[i] = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(cal_pkg::ADDR_STAT, 32'h0000_0000, "status");
    rdchk(12'h114, 32'h0000_0000, "gpr");
    rdchk(12'hFFC, 32'h0000_0000, "unmapped");
    $display("test reset done");
    for (i = 0; i < 32; i++) begin
      r = rnd();
      mgpr[i] = r[7:0];
      apb(1'b1, {cal_pkg::PAGE_GPR, 1'b0, 5'(i), 2'h0}, {24'h0, r[7:0]});
    end
    // codes 00 to 0E with random operands and flags
    for (i = 0; i < 75; i++) begin
      op = 5'(i % 15);
      r = rnd();
      dst = r[4:0];
      src = r[12:8];
      k = r[23:16];
      if (op >= cal_pkg::OP_PAIR_PLUS) dst[0] = 1'b0;
      mfl = {2'h0, r[29:24]};
      apb(1'b1, cal_pkg::ADDR_FLAGS, {24'h0, mfl});
      alu(op, dst, src, k);
      cmd(op, {1'b0, dst}, src, k);
      chk("flags", {24'h0, mfl}, {24'h0, rd_q[7:0]});
      rdchk({4'h1, 1'b0, dst, 2'h0}, {24'h0, mgpr[dst]}, "res");
      if (op >= cal_pkg::OP_PAIR_PLUS)
        rdchk({4'h1, 1'b0, dst + 5'h1, 2'h0}, {24'h0, mgpr[dst+1]}, "hi");
    end
    $display("test arith done");
    @(posedge pclk);
    flag_event <= 8'hFF;
    @(posedge pclk);
    flag_event <= 8'h00;
    mio[11] = mio[11] | cal_pkg::IO_W1C_MASK;
    for (i = 0; i < 10; i++) begin
      a = ia[i];
      m = (a == cal_pkg::IO_FLAG_ADDR) ? cal_pkg::IO_W1C_MASK : 8'h00;
      o = mio[a];
      if (kd[i] == 0) d = iv[i];
      else if (kd[i] == 1) d = (o & ~m) | (8'h01 << iv[i][2:0]);
      else d = o & ~m & ~(8'h01 << iv[i][2:0]);
      if (kd[i] == 0 || a <= cal_pkg::IO_BIT_TOP)
        mio[a] = (d & ~m) | (o & m & ~d);
      if (kd[i] == 0) begin
        apb(1'b1, {cal_pkg::PAGE_IO, a, 2'h0}, {24'h0, d});
      end else begin
        cmd(kd[i] == 1 ? cal_pkg::OP_IO_SET : cal_pkg::OP_IO_CLR, a,
            {2'h0, iv[i][2:0]}, 8'h00);
        chk("illegal", {31'h0, a > cal_pkg::IO_BIT_TOP},
            {31'h0, rd_q[cal_pkg::ST_ILLEGAL]});
      end
      rdchk({cal_pkg::PAGE_IO, a, 2'h0}, {24'h0, mio[a]}, "io");
      chk("port", {24'h0, mio[24]}, {24'h0, io_port_q});
    end
    $display("test io done");
    // both skip tests on set and clear bits
    for (i = 0; i < 8; i++) begin
      b = i % 4;
      op = (i < 4) ? cal_pkg::OP_SKIP_HIGH : cal_pkg::OP_SKIP_LOW;
      cmd(op, 6'h18, 5'(b), 8'h00);
      chk("skip", {31'h0, mio[24][b] ^ (i >= 4)},
          {31'h0, rd_q[cal_pkg::ST_SKIP]});
      chk("skip_next", {31'h0, mio[24][b] ^ (i >= 4)}, {31'h0, skip_next});
    end
    $display("test skip done");
    test_done();
  end
endmodule
